// ===== hdl/tmr_pkg.sv
// Timer module constants and types
package tmr_pkg;

  // ----------------------------------------------------------------
  // Configuration register encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_32_OSP = 3'h0;   // 32-bit one-shot/periodic
  localparam logic [2:0] CFG_RTC = 3'h1;      // 32-bit real-time clock
  localparam logic [2:0] CFG_16 = 3'h4;       // Two independent halves

  // ----------------------------------------------------------------
  // Half mode field and event field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam logic [1:0] EVT_RISE = 2'h0;
  localparam logic [1:0] EVT_FALL = 2'h1;
  localparam logic [1:0] EVT_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Counter values
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_RESET = 16'hffff;  // Counter and capture at reset
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [31:0] RTC_PRESET = 32'h00000001; // First RTC selection
  localparam logic [31:0] RTC_WRAP = 32'h00000000;   // Value after a match
  localparam logic [31:0] RTC_ONE = 32'h00000001;

  // ----------------------------------------------------------------
  // RTC divider: edges per 1 Hz tick
  // ----------------------------------------------------------------
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int RTC_DIV_EDGES = RTC_IN_HZ / RTC_TICK_HZ;
  localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_DIV_EDGES - 1);
  localparam logic [14:0] RTC_DIV_ZERO = 15'h0000;
  localparam logic [14:0] RTC_DIV_ONE = 15'h0001;

  // ----------------------------------------------------------------
  // Flag bit layout shared by raw, mask, clear
  // ----------------------------------------------------------------
  localparam int FLG_W = 7;
  localparam int FLG_TO = 0;   // Time-out + half
  localparam int FLG_CM = 2;   // Capture match + half
  localparam int FLG_CE = 4;   // Capture event + half
  localparam int FLG_RTC = 6;  // RTC match

  // ----------------------------------------------------------------
  // Decoded half mode, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    HM_IDLE = 5'b00001,
    HM_OSP = 5'b00010,
    HM_PWM = 5'b00100,
    HM_ECNT = 5'b01000,
    HM_ETIM = 5'b10000
  } tmr_hmode_type;

  // State of one 16-bit half
  typedef struct packed {
    logic [15:0] cnt;   // Live counter
    logic [15:0] capt;  // Captured count in edge time mode
    logic en;           // Half enable
    logic to_raw;       // Raw time-out flag
    logic cm_raw;       // Raw capture match flag
    logic ce_raw;       // Raw capture event flag
    logic pwm;          // PWM level before inversion
  } tmr_half_type;

endpackage

// ===== hdl/tmr_edge.sv
// Pin synchroniser and edge detector with event selection
`timescale 1ns/1ps
`default_nettype none
module tmr_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic pin_in,
  input wire logic [1:0] evt_sel,
  output logic rise,
  output logic evt
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic s1;    // First sync stage, read only by s2
    logic s2;    // Second sync stage
    logic prev;  // Previous synchronised level
  } tmr_edge_type;

  tmr_edge_type st_ff;
  tmr_edge_type nxt_st;
  logic fall;

  // Shift the pin through the stages
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.prev = st_ff.s2;
  end

  // Register, frozen while clk_en low
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Edges seen only after two stages; slow pins are assumed
  assign rise = st_ff.s2 & ~st_ff.prev;
  assign fall = ~st_ff.s2 & st_ff.prev;

  // Event selection
  always_comb begin
    case (evt_sel)
      EVT_RISE: evt = rise;
      EVT_FALL: evt = fall;
      EVT_BOTH: evt = rise | fall;
      default: evt = 1'b0;  // Reserved: no events
    endcase
  end

endmodule // tmr_edge
`default_nettype wire

// ===== hdl/tmr_presc.sv
// Eight-bit prescaler that paces a half's down-counter
`timescale 1ns/1ps
`default_nettype none
module tmr_presc #(
  parameter int PW = 8  // Prescale width
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic run,
  input wire logic restart,
  input wire logic [PW-1:0] presc_val,
  output logic tick
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [PW-1:0] cnt;  // Clocks on current count
  } tmr_presc_type;

  tmr_presc_type st_ff;
  tmr_presc_type nxt_st;

  assign tick = run && (st_ff.cnt == presc_val);

  // Restart on reload or stop, wrap on tick
  always_comb begin
    nxt_st = st_ff;
    if (restart || !run || tick) begin
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + PW'(1);
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

endmodule // tmr_presc
`default_nettype wire

// ===== hdl/tmr_timer.sv
// Timer module: 32-bit RTC mode and the 16-bit modes of both halves
`timescale 1ns/1ps
`default_nettype none

module tmr_timer #(
  parameter int NH = 2  // Number of halves
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [2:0] configuration_register,
  input wire logic [NH-1:0][1:0] half_mode_field,
  input wire logic [NH-1:0] capture_mode_bit,
  input wire logic [NH-1:0] alternate_mode_bit,
  input wire logic [NH-1:0][1:0] half_event_select,
  input wire logic [NH-1:0] pwm_output_level_bit,
  input wire logic [NH-1:0] half_debug_stall,
  input wire logic rtc_stall_override_enable,
  input wire logic debug_halt,
  input wire logic [NH-1:0][15:0] half_interval_load,
  input wire logic [NH-1:0] interval_load_write,
  input wire logic [NH-1:0][7:0] half_prescale_register,
  input wire logic [NH-1:0][15:0] half_match_register,
  input wire logic [NH-1:0] enable_write,
  input wire logic [NH-1:0] enable_write_data,
  input wire logic [tmr_pkg::FLG_W-1:0] interrupt_mask_register,
  input wire logic [tmr_pkg::FLG_W-1:0] flag_clear_register,
  input wire logic [NH-1:0] capture_pwm_pin_in,
  output logic [NH-1:0] capture_pwm_pin_out,
  output logic [NH-1:0] capture_pwm_pin_oe,
  output logic [NH-1:0] half_enable,
  output logic [NH-1:0][15:0] half_count_value_register,
  output logic [tmr_pkg::FLG_W-1:0] raw_flag_register,
  output logic [tmr_pkg::FLG_W-1:0] masked_flag_register,
  output logic timer_irq
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // State of the whole module
  // ----------------------------------------------------------------
  typedef struct packed {
    tmr_half_type [NH-1:0] half;  // Both 16-bit halves
    logic [31:0] rtc_cnt;         // Joined RTC counter
    logic [14:0] rtc_div;         // Edges towards one second
    logic rtc_seen;               // RTC mode selected at least once
    logic rtc_raw;                // Raw RTC match flag
  } tmr_state_type;

  tmr_state_type st_ff;
  tmr_state_type nxt_st;

  // ----------------------------------------------------------------
  // Per-half, configuration and RTC helpers
  // ----------------------------------------------------------------
  tmr_hmode_type hmode [NH];   // Decoded mode per half
  logic [NH-1:0] half_active;  // Enabled, in 16-bit config and not stalled
  logic [NH-1:0] presc_tick;   // Prescaler pace
  logic [NH-1:0] pin_rise;     // Synchronised rising edge
  logic [NH-1:0] pin_evt;      // Selected capture event
  logic rtc_mode;              // Config selects the RTC
  logic half_mode;             // Config selects 16-bit halves
  logic rtc_run;               // RTC allowed to advance
  logic rtc_tick;              // One-second tick into the RTC
  logic [31:0] rtc_match;      // Joined match value

  // Mode decode per half
  function automatic tmr_hmode_type tmr_decode(
    input logic [1:0] mode,
    input logic cmr,
    input logic ams
  );
    tmr_hmode_type res;
    res = HM_IDLE;
    if (ams && !cmr && (mode == MODE_PERIODIC)) begin
      res = HM_PWM;
    end else if (!ams && ((mode == MODE_ONESHOT) || (mode == MODE_PERIODIC))) begin
      res = HM_OSP;
    end else if (!ams && (mode == MODE_CAPTURE)) begin
      res = cmr ? HM_ETIM : HM_ECNT;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  // value one selects the RTC
  assign rtc_mode = (configuration_register == CFG_RTC);
  assign half_mode = (configuration_register == CFG_16);

  assign rtc_run = rtc_stall_override_enable || !(debug_halt && (|half_debug_stall));

  // Match value of the joined counter
  assign rtc_match = {half_match_register[1], half_match_register[0]};

  // ----------------------------------------------------------------
  // Per-half instances
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NH; gi++) begin : g_half
      // Mode of this half
      assign hmode[gi] = tmr_decode(half_mode_field[gi], capture_mode_bit[gi],
                                    alternate_mode_bit[gi]);

      assign half_active[gi] = st_ff.half[gi].en && half_mode &&
                               !(half_debug_stall[gi] && debug_halt);

      tmr_presc #(
        .PW(8)
      ) u_presc (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .run(half_active[gi] && (hmode[gi] == HM_OSP)),
        .restart(interval_load_write[gi]),
        .presc_val(half_prescale_register[gi]),
        .tick(presc_tick[gi])
      );

      // relies on pins slower than a quarter clock
      tmr_edge u_edge (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in(capture_pwm_pin_in[gi]),
        .evt_sel(half_event_select[gi]),
        .rise(pin_rise[gi]),
        .evt(pin_evt[gi])
      );

      assign capture_pwm_pin_out[gi] = st_ff.half[gi].pwm ^ pwm_output_level_bit[gi];
      // Drive pin only in PWM mode
      assign capture_pwm_pin_oe[gi] = half_mode && (hmode[gi] == HM_PWM);
      assign half_enable[gi] = st_ff.half[gi].en;
    end
  endgenerate

  // one tick per 32768 even-pin rising edges
  assign rtc_tick = pin_rise[0] && (st_ff.rtc_div == RTC_DIV_LAST);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Clears first, so a set in the same cycle wins
    nxt_st.rtc_raw = st_ff.rtc_raw & ~flag_clear_register[FLG_RTC];
    for (int i = 0; i < NH; i++) begin
      nxt_st.half[i].to_raw = st_ff.half[i].to_raw & ~flag_clear_register[FLG_TO + i];
      nxt_st.half[i].cm_raw = st_ff.half[i].cm_raw & ~flag_clear_register[FLG_CM + i];
      nxt_st.half[i].ce_raw = st_ff.half[i].ce_raw & ~flag_clear_register[FLG_CE + i];
      // Software enable write; hardware clears below win
      if (enable_write[i]) begin
        nxt_st.half[i].en = enable_write_data[i];
      end
    end

    // 16-bit halves
    for (int i = 0; i < NH; i++) begin
      case (hmode[i])
        HM_OSP: begin
          if (half_mode && interval_load_write[i]) begin
            nxt_st.half[i].cnt = half_interval_load[i];
          end else if (half_active[i] && presc_tick[i]) begin
            if (st_ff.half[i].cnt == CNT_ZERO) begin
              nxt_st.half[i].cnt = half_interval_load[i];
              if (half_mode_field[i] == MODE_ONESHOT) begin
                nxt_st.half[i].en = 1'b0;
              end
              nxt_st.half[i].to_raw = 1'b1;
            end else begin
              nxt_st.half[i].cnt = st_ff.half[i].cnt - CNT_ONE;
            end
          end
        end
        HM_PWM: begin
          if (half_mode && interval_load_write[i]) begin
            // Period change takes effect next cycle
            nxt_st.half[i].cnt = half_interval_load[i];
          end else if (half_active[i]) begin
            // count down, reload after zero, no flags
            if (st_ff.half[i].cnt == CNT_ZERO) begin
              nxt_st.half[i].cnt = half_interval_load[i];
            end else begin
              nxt_st.half[i].cnt = st_ff.half[i].cnt - CNT_ONE;
            end
          end
          // set at start state, clear at match
          if (st_ff.half[i].cnt == half_interval_load[i]) begin
            nxt_st.half[i].pwm = 1'b1;
          end else if (st_ff.half[i].cnt == half_match_register[i]) begin
            nxt_st.half[i].pwm = 1'b0;
          end
        end
        HM_ECNT: begin
          if (half_mode && interval_load_write[i]) begin
            nxt_st.half[i].cnt = half_interval_load[i];
          end else if (half_active[i] && pin_evt[i]) begin
            // one step per event until match
            if ((st_ff.half[i].cnt - CNT_ONE) == half_match_register[i]) begin
              nxt_st.half[i].cm_raw = 1'b1;
              nxt_st.half[i].cnt = half_interval_load[i];
              nxt_st.half[i].en = 1'b0;
            end else begin
              nxt_st.half[i].cnt = st_ff.half[i].cnt - CNT_ONE;
            end
          end
        end
        HM_ETIM: begin
          if (half_mode && interval_load_write[i]) begin
            nxt_st.half[i].cnt = half_interval_load[i];
          end else if (half_active[i]) begin
            if (st_ff.half[i].cnt == CNT_ZERO) begin
              nxt_st.half[i].cnt = half_interval_load[i];
            end else begin
              nxt_st.half[i].cnt = st_ff.half[i].cnt - CNT_ONE;
            end
          end
          if (half_active[i] && pin_evt[i]) begin
            // capture count and flag the event
            nxt_st.half[i].capt = st_ff.half[i].cnt;
            nxt_st.half[i].ce_raw = 1'b1;
          end
        end
        default: begin
          // Idle code: nothing moves
        end
      endcase
    end

    // Real-time clock on the joined counter
    if (rtc_mode && !st_ff.rtc_seen) begin
      nxt_st.rtc_cnt = RTC_PRESET;
      nxt_st.rtc_seen = 1'b1;
      nxt_st.rtc_div = RTC_DIV_ZERO;
    end else if (rtc_mode && st_ff.half[0].en) begin
      if (rtc_run && pin_rise[0]) begin
        // divide the slow clock to 1 Hz
        if (rtc_tick) begin
          nxt_st.rtc_div = RTC_DIV_ZERO;
        end else begin
          nxt_st.rtc_div = st_ff.rtc_div + RTC_DIV_ONE;
        end
      end
      if (rtc_run && rtc_tick) begin
        if (st_ff.rtc_cnt == rtc_match) begin
          nxt_st.rtc_cnt = RTC_WRAP;
          nxt_st.rtc_raw = 1'b1;
        end else begin
          nxt_st.rtc_cnt = st_ff.rtc_cnt + RTC_ONE;
        end
      end
    end else begin
      // Divider restarts while RTC deselected or half 0 disabled
      nxt_st.rtc_div = RTC_DIV_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Sync reset; clock enable freezes all
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
      for (int i = 0; i < NH; i++) begin
        st_ff.half[i].cnt <= CNT_RESET;
        st_ff.half[i].capt <= CNT_RESET;
      end
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Readable count: RTC, capture or live
  always_comb begin
    for (int i = 0; i < NH; i++) begin
      if (hmode[i] == HM_ETIM) begin
        half_count_value_register[i] = st_ff.half[i].capt;
      end else begin
        half_count_value_register[i] = st_ff.half[i].cnt;
      end
    end
    if (rtc_mode) begin
      half_count_value_register[0] = st_ff.rtc_cnt[15:0];
      half_count_value_register[1] = st_ff.rtc_cnt[31:16];
    end
  end

  // Raw flag vector
  always_comb begin
    raw_flag_register = '0;
    for (int i = 0; i < NH; i++) begin
      raw_flag_register[FLG_TO + i] = st_ff.half[i].to_raw;
      raw_flag_register[FLG_CM + i] = st_ff.half[i].cm_raw;
      raw_flag_register[FLG_CE + i] = st_ff.half[i].ce_raw;
    end
    raw_flag_register[FLG_RTC] = st_ff.rtc_raw;
  end

  // masked flags and one interrupt line
  assign masked_flag_register = raw_flag_register & interrupt_mask_register;
  assign timer_irq = |masked_flag_register;

endmodule // tmr_timer
`default_nettype wire

// ===== bench/tmr_timer_sva.sv
// Port-level checker of the timer module
`timescale 1ns/1ps
`default_nettype none
module tmr_timer_sva #(
  parameter int NH = 2  // Number of halves
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] configuration_register,
  input wire logic [NH-1:0][1:0] half_mode_field,
  input wire logic [NH-1:0] capture_mode_bit,
  input wire logic [NH-1:0] alternate_mode_bit,
  input wire logic [NH-1:0] half_debug_stall,
  input wire logic debug_halt,
  input wire logic [NH-1:0][15:0] half_interval_load,
  input wire logic [NH-1:0] interval_load_write,
  input wire logic [NH-1:0][7:0] half_prescale_register,
  input wire logic [NH-1:0] enable_write,
  input wire logic [tmr_pkg::FLG_W-1:0] interrupt_mask_register,
  input wire logic [tmr_pkg::FLG_W-1:0] flag_clear_register,
  input wire logic [NH-1:0] capture_pwm_pin_oe,
  input wire logic [NH-1:0] half_enable,
  input wire logic [NH-1:0][15:0] half_count_value_register,
  input wire logic [tmr_pkg::FLG_W-1:0] raw_flag_register,
  input wire logic [tmr_pkg::FLG_W-1:0] masked_flag_register,
  input wire logic timer_irq
);
  import tmr_pkg::*;
  // Short aliases
  wire logic m16 = configuration_register == CFG_16;
  wire logic [15:0] c0 = half_count_value_register[0];
  wire logic [15:0] c1 = half_count_value_register[1];
  wire logic [FLG_W-1:0] rf = raw_flag_register;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mask_and: assert property (masked_flag_register == (rf & interrupt_mask_register))
    else $error("masked flags wrong");
  a_irq_any: assert property (timer_irq == (|masked_flag_register))
    else $error("interrupt wrong");
  a_flag_sticky: assert property (rf[0] && !flag_clear_register[0] |=> rf[0])
    else $error("time-out flag dropped");
  a_rtc_clear: assert property (flag_clear_register[FLG_RTC] && !configuration_register[0]
    |=> !rf[FLG_RTC]) else $error("rtc flag not cleared");
  a_oneshot_end: assert property (m16 && half_mode_field[0] == MODE_ONESHOT && $rose(rf[0])
    |-> !half_enable[0] && c0 == half_interval_load[0]) else $error("one-shot end wrong");
  a_periodic_on: assert property (m16 && half_mode_field[1] == MODE_PERIODIC && $rose(rf[1])
    |-> half_enable[1]) else $error("periodic half stopped");
  a_load_next: assert property (m16 && interval_load_write[1]
    && half_mode_field[1] != MODE_CAPTURE |=> c1 == $past(half_interval_load[1]))
    else $error("load write not taken");
  a_down_step: assert property (m16 && half_enable[0] && half_mode_field[0] == MODE_ONESHOT
    && !alternate_mode_bit[0] && half_prescale_register[0] == 8'h00 && c0 != CNT_ZERO
    && !interval_load_write[0] && !enable_write[0] && !debug_halt
    |=> c0 == $past(c0) - CNT_ONE) else $error("bad count step");
  a_halt_freeze: assert property ((m16 && half_debug_stall[1] && debug_halt
    && !interval_load_write[1]) [*2] |-> $stable(c1)) else $error("half ran in halt");
  a_pwm_decode: assert property (capture_pwm_pin_oe[0] == (m16 && alternate_mode_bit[0]
    && !capture_mode_bit[0] && half_mode_field[0] == MODE_PERIODIC)) else $error("pwm decode");
  a_ecnt_end: assert property (m16 && !capture_mode_bit[0] && $rose(rf[FLG_CM])
    |-> !half_enable[0] && c0 == half_interval_load[0]) else $error("edge count end");
endmodule // tmr_timer_sva
`default_nettype wire

// ===== bench/tmr_pin_model.sv
// Far-side capture pin source: bursts of level changes
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [4:0] edges,
  output logic pin,
  output logic busy
);
  logic pin_ff = 1'b0;  // Held still between bursts
  logic [4:0] left_ff = 5'h00;  // Changes left
  logic [1:0] wait_ff = 2'h0;  // Clocks to next change
  assign pin = pin_ff;
  assign busy = left_ff != 5'h00;
  always_ff @(posedge clk) begin
    if (start) begin
      left_ff <= edges;
      wait_ff <= 2'h3;
    end else if (busy && wait_ff != 2'h0) begin
      wait_ff <= wait_ff - 2'h1;
    end else if (busy) begin
      pin_ff <= ~pin_ff;
      left_ff <= left_ff - 5'h01;
      wait_ff <= 2'h3;
    end
  end
endmodule // tmr_pin_model
`default_nettype wire

// ===== bench/tmr_timer_tb.sv
// Self-checking bench of the timer module
`timescale 1ns/1ps
`default_nettype none
module tmr_timer_tb;
  import tmr_pkg::*;
  logic clk, rst, clk_en, debug_halt, rtc_stall_override_enable, timer_irq;
  logic [2:0] configuration_register;
  logic [1:0][1:0] half_mode_field, half_event_select;
  logic [1:0] capture_mode_bit, alternate_mode_bit, pwm_output_level_bit, half_debug_stall;
  logic [1:0] interval_load_write, enable_write, enable_write_data, st, busy;
  logic [1:0] capture_pwm_pin_out, capture_pwm_pin_oe, half_enable;
  logic [1:0][15:0] half_interval_load, half_match_register, half_count_value_register;
  logic [1:0][7:0] half_prescale_register;
  logic [6:0] interrupt_mask_register, flag_clear_register, raw_flag_register, masked_flag_register;
  logic [4:0] ne;
  logic [15:0] cv;
  wire logic [1:0] capture_pwm_pin_in;
  int check_count = 0, fail_count = 0, hi;
  time t0;
  tmr_timer #(.NH(2)) u_tmr_timer (.clk, .rst, .clk_en, .configuration_register,
    .half_mode_field, .capture_mode_bit, .alternate_mode_bit, .half_event_select,
    .pwm_output_level_bit, .half_debug_stall, .rtc_stall_override_enable, .debug_halt,
    .half_interval_load, .interval_load_write, .half_prescale_register, .half_match_register,
    .enable_write, .enable_write_data, .interrupt_mask_register, .flag_clear_register,
    .capture_pwm_pin_in, .capture_pwm_pin_out, .capture_pwm_pin_oe, .half_enable,
    .half_count_value_register, .raw_flag_register, .masked_flag_register, .timer_irq);
  // Pin sources
  tmr_pin_model u_pin0 (.clk, .start(st[0]), .edges(ne), .pin(capture_pwm_pin_in[0]),
    .busy(busy[0]));
  tmr_pin_model u_pin1 (.clk, .start(st[1]), .edges(ne), .pin(capture_pwm_pin_in[1]),
    .busy(busy[1]));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // k<7: raw flag; else pin burst end
  task automatic wt(input int k);
    int i;
    for (i = 0; i < 3000; i++) begin
      tick(1);
      if (k < 7 ? raw_flag_register[k] === 1'b1 : busy[k-7] === 1'b0) break;
    end
    if (i == 3000) begin
      fail_count++;
      $display("Error %0t: wait %0d timeout", $time, k);
      report_and_stop();
    end
  endtask
  task automatic ldw(input int h);
    @(posedge clk) interval_load_write[h] <= 1'b1;
    @(posedge clk) interval_load_write[h] <= 1'b0;
    #1;
  endtask
  task automatic enw(input int h, input logic d);
    @(posedge clk) enable_write[h] <= 1'b1;
    enable_write_data[h] <= d;
    @(posedge clk) enable_write[h] <= 1'b0;
    #1;
  endtask
  task automatic clr(input logic [6:0] m);
    @(posedge clk) flag_clear_register <= m;
    @(posedge clk) flag_clear_register <= 7'h00;
    #1;
  endtask
  task automatic pins(input int h, input logic [4:0] n);
    @(posedge clk) st[h] <= 1'b1;
    ne <= n;
    @(posedge clk) st[h] <= 1'b0;
    wt(7 + h);
  endtask
  initial begin
    {rst, clk_en, debug_halt, rtc_stall_override_enable, st, ne} = 11'h600;
    {half_mode_field, half_event_select, capture_mode_bit, alternate_mode_bit} = '0;
    {pwm_output_level_bit, half_debug_stall, interval_load_write, enable_write} = '0;
    {enable_write_data, half_interval_load, half_match_register, half_prescale_register} = '0;
    {interrupt_mask_register, flag_clear_register} = '0;
    configuration_register = CFG_16;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk({half_enable, raw_flag_register}, 32'h0);
    chk(half_count_value_register, 32'hffffffff);
    @(posedge clk);
    half_mode_field[0] <= MODE_ONESHOT;
    half_interval_load[0] <= 16'h0002;
    interrupt_mask_register <= 7'h01;
    ldw(0);
    chk(half_count_value_register[0], 32'h2);
    enw(0, 1'b1);
    wt(0);
    chk({half_enable[0], half_count_value_register[0]}, 32'h2);
    chk({timer_irq, masked_flag_register}, 32'h81);
    clr(7'h41);
    chk(raw_flag_register, 32'h0);
    $display("test one-shot done");
    @(posedge clk);
    half_mode_field[1] <= MODE_PERIODIC;
    half_interval_load[1] <= 16'h0003;
    half_prescale_register[1] <= 8'h02;
    ldw(1);
    enw(1, 1'b1);
    wt(1);
    t0 = $time;
    clr(7'h02);
    wt(1);
    chk(32'(($time - t0) / 25), 32'hc);
    chk(half_enable[1], 32'h1);
    @(posedge clk);
    half_debug_stall[1] <= 1'b1;
    debug_halt <= 1'b1;
    tick(2);
    cv = half_count_value_register[1];
    tick(20);
    chk(half_count_value_register[1], cv);
    @(posedge clk) debug_halt <= 1'b0;
    tick(8);
    chk(half_count_value_register[1] !== cv, 32'h1);
    enw(1, 1'b0);
    $display("test periodic done");
    // Rise, fall, both: four counted, rest ignored
    for (int e = 0; e < 4; e++) if (e != 2) begin
      @(posedge clk);
      half_mode_field[0] <= MODE_CAPTURE;
      half_event_select[0] <= 2'(e);
      half_interval_load[0] <= 16'h000a;
      half_match_register[0] <= 16'h0006;
      half_prescale_register[0] <= 8'hff;
      ldw(0);
      enw(0, 1'b1);
      pins(0, e == 3 ? 5'h08 : 5'h10);
      tick(6);
      chk({half_enable[0], raw_flag_register[2], half_count_value_register[0]}, 32'h1000a);
      clr(7'h04);
    end
    $display("test edge count done");
    @(posedge clk);
    half_mode_field[1] <= MODE_CAPTURE;
    capture_mode_bit[1] <= 1'b1;
    half_interval_load[1] <= 16'hffff;
    ldw(1);
    enw(1, 1'b1);
    tick(30);
    pins(1, 5'h02);
    wt(5);
    cv = half_count_value_register[1];
    chk(cv < 16'hffe0 && cv > 16'hff00, 32'h1);
    tick(12);
    chk(half_count_value_register[1], cv);
    enw(1, 1'b0);
    $display("test edge time done");
    for (int l = 0; l < 2; l++) begin
      @(posedge clk);
      half_mode_field[0] <= MODE_PERIODIC;
      alternate_mode_bit[0] <= 1'b1;
      pwm_output_level_bit[0] <= l[0];
      half_interval_load[0] <= 16'h0009;
      half_match_register[0] <= 16'h0003;
      ldw(0);
      enw(0, 1'b1);
      tick(12);
      hi = 0;
      repeat (20) begin
        tick(1);
        hi += capture_pwm_pin_out[0];
      end
      chk({capture_pwm_pin_oe[0], 8'(hi)}, l ? 32'h108 : 32'h10c);
      enw(0, 1'b0);
    end
    $display("test pwm done");
    @(posedge clk) configuration_register <= CFG_RTC;
    tick(3);
    chk(half_count_value_register, 32'h1);
    $display("test rtc preset done");
    report_and_stop();
  end
endmodule // tmr_timer_tb
bind tmr_timer tmr_timer_sva #(.NH(NH)) u_tmr_timer_sva (.clk, .rst, .configuration_register,
  .half_mode_field, .capture_mode_bit, .alternate_mode_bit, .half_debug_stall, .debug_halt,
  .half_interval_load, .interval_load_write, .half_prescale_register, .enable_write,
  .interrupt_mask_register, .flag_clear_register, .capture_pwm_pin_oe, .half_enable,
  .half_count_value_register, .raw_flag_register, .masked_flag_register, .timer_irq);
`default_nettype wire
